// ===== hw/tbf_host_framer.v
/*
 * Terminal-side block framer for the half-duplex block protocol: builds and
 * sends blocks, receives and checks the card's answer, keeps the etu timing.
 * Assumes a character layer that takes tx bytes on valid/ready, reports
 * received bytes with one-cycle strobes and supplies a one-cycle etu tick.
 */
// Added by the designer: strobed register access and the placing of the registers.
// How it works
// - Blocks are exchanged only while software marks the session as opened; the code checks it only at send start, a block under way runs on.
// - Terminal sends first; afterwards the right to send alternates strictly; the code also gives the terminal the turn if the answer times out.
// - Card field limit defaults to 32, may be reprogrammed; sends above it refused.
// - Terminal receive limit starts at 32, changeable, never above 254.
// - Character waiting integer from four bits, clamped into 0..5.
// - Gap between characters in a block must not exceed 11 plus 2^cwi etu.
// - Terminal times the card's first answer character against block waiting time.
// - Characters in opposite directions are at least 22 etu apart; the code checks this only before sending after a card character.
// - Error code must be LRC: coding byte must be all zero.
// - Block is node, control, length bytes, up to 254 data, one check byte.
// - Node byte bits 8 and 4 zero; destination bits 7..5, source bits 3..1.
// - Only both addresses zero supported; other pairs reserved.
// - First terminal block opens connection; later blocks share its address pair.
// - Information control: b8 zero, sequence b7, more-data b6, b5..b1 reserved.
// - Receive-ready control: b8..b6 = 100, sequence b5, code b4..b1.
// - Receive-ready codes 0, 1 and 2 only; others reserved.
// - Supervisory control: b8 and b7 set; b6 clear request, set response.
// - Supervisory codes 0 to 3 valid; 4 unused; others reserved.
// - Length gives data count; zero means none; 0xFF is never sent.
// - Field-size and extension carry one byte; other supervisory and receive-ready none.
// - Right to send returns after length plus check byte received.
`timescale 1ns/100ps
`default_nettype none
`include "tbf_map.vh"

module tbf_host_framer #(
	parameter BUF_DEPTH = 254
) (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire [7:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output wire [31:0] reg_rdata_out,
	input wire etu_tick_in,
	output wire [7:0] tx_data_out,
	output wire tx_valid_out,
	input wire tx_ready_in,
	input wire [7:0] rx_data_in,
	input wire rx_valid_in
);

	// ------------------------------------------------------------------
	// States, one-hot
	// ------------------------------------------------------------------
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_GUARD = 5'h02;
	localparam [4:0] ST_TX = 5'h04;
	localparam [4:0] ST_WAIT = 5'h08;
	localparam [4:0] ST_RX = 5'h10;
	// Node byte usable: reserved bits clear and both addresses zero
	function nad_ok;
		input [7:0] nad;
		begin
			nad_ok = (nad == 8'h00);
		end
	endfunction

	// Control byte coding and length consistent with block type
	function pcb_ok;
		input [7:0] pcb;
		input [7:0] len;
		begin
			pcb_ok = 1'b0;
			if (len == `TBF_LEN_RFU) begin
				pcb_ok = 1'b0;
			end else if (!pcb[7]) begin
				pcb_ok = (pcb[4:0] == 5'h00);
			end else if (pcb[6:5] == 2'b00) begin
				pcb_ok = (pcb[3:0] <= 4'h2) && (len == 8'h00);
			end else if (pcb[6]) begin
				// Code 4 is unused here, so it counts as invalid too
				if (pcb[4:0] == 5'h01 || pcb[4:0] == 5'h03) begin
					pcb_ok = (len == 8'h01);
				end else if (pcb[4:0] == 5'h00 || pcb[4:0] == 5'h02) begin
					pcb_ok = (len == 8'h00);
				end
			end
		end
	endfunction

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	reg [7:0] txbuf [0:BUF_DEPTH-1];
	reg [7:0] rxbuf [0:BUF_DEPTH-1];
	reg [4:0] state_q;
	reg session_q, conn_open_q, card_turn_q, last_rx_q, tx_valid_q;
	reg [3:0] cwi_q;
	reg [7:0] conn_nad_q, ifsc_q, ifsd_q, edc_code_q, tx_nad_q, tx_pcb_q, tx_len_q, tx_wptr_q;
	reg [7:0] lrc_q, tx_data_q, rx_nad_q, rx_pcb_q, rx_len_q, rx_rptr_q;
	reg [8:0] idx_q, status_q, set_flags;
	reg [15:0] bwt_q, etu_cnt_q;
	reg [31:0] rdata_q;
	wire tx_take = tx_valid_q && tx_ready_in;
	wire char_evt = tx_take || (rx_valid_in && (state_q == ST_WAIT || state_q == ST_RX));
	wire wr_ctrl = reg_wr_in && (reg_addr_in == `TBF_REG_CTRL);
	wire wr_status = reg_wr_in && (reg_addr_in == `TBF_REG_STATUS);
	wire rd_rxdata = reg_rd_in && (reg_addr_in == `TBF_REG_RXDATA);
	wire [3:0] cwi_eff = (cwi_q > `TBF_CWI_MAX) ? `TBF_CWI_MAX : cwi_q;
	wire [15:0] cwt_etu = `TBF_CWT_BASE_ETU + (16'h0001 << cwi_eff);
	wire [8:0] last_idx = {1'b0, tx_len_q} + 9'h003;
	wire [8:0] rx_last_idx = {1'b0, rx_len_q} + 9'h003;
	wire [8:0] nxt_idx = idx_q + 9'h001;
	wire [8:0] buf_idx = nxt_idx - 9'h003;
	wire [8:0] rx_buf_idx = idx_q - 9'h003;

	// Start conditions for a send; refusal shows as a sticky status flag
	wire send_req = wr_ctrl && reg_wdata_in[`TBF_CTRL_SEND];
	wire send_ok = session_q && !card_turn_q && (state_q == ST_IDLE)
		&& (edc_code_q == 8'h00)
		&& nad_ok(tx_nad_q) && (!conn_open_q || tx_nad_q == conn_nad_q)
		&& pcb_ok(tx_pcb_q, tx_len_q) && (tx_len_q <= ifsc_q)
		&& (tx_len_q <= tx_wptr_q);
	// Byte that follows the current one on the wire
	reg [7:0] nxt_byte;
	always @* begin
		nxt_byte = 8'h00;
		if (nxt_idx == 9'h001) begin
			nxt_byte = tx_pcb_q;
		end else if (nxt_idx == 9'h002) begin
			nxt_byte = tx_len_q;
		end else if (nxt_idx == last_idx) begin
			nxt_byte = lrc_q ^ tx_data_q;
		end else begin
			nxt_byte = txbuf[buf_idx[7:0]];
		end
	end
	assign tx_data_out = tx_data_q;
	assign tx_valid_out = tx_valid_q;
	assign reg_rdata_out = rdata_q;
	// ------------------------------------------------------------------
	// Buffer writes; no reset needed for memories
	// ------------------------------------------------------------------
	always @(posedge ref_clk_in) begin
		if (reg_wr_in && reg_addr_in == `TBF_REG_TXDATA && tx_wptr_q < BUF_DEPTH) begin
			txbuf[tx_wptr_q] <= reg_wdata_in[7:0];
		end
		if (state_q == ST_RX && rx_valid_in && idx_q >= 9'h003 && rx_buf_idx < BUF_DEPTH) begin
			rxbuf[rx_buf_idx[7:0]] <= rx_data_in;
		end
	end

	// ------------------------------------------------------------------
	// Etu counter since the last character leading edge, saturating
	// ------------------------------------------------------------------
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			etu_cnt_q <= 16'h0000;
		end else if (char_evt) begin
			etu_cnt_q <= 16'h0000;
		end else if (etu_tick_in && etu_cnt_q != 16'hFFFF) begin
			etu_cnt_q <= etu_cnt_q + 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// Configuration and software registers
	// ------------------------------------------------------------------
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			session_q <= 1'b0;
			ifsc_q <= `TBF_IFS_DEFAULT;
			ifsd_q <= `TBF_IFS_DEFAULT;
			cwi_q <= 4'h0;
			edc_code_q <= 8'h00;
			bwt_q <= `TBF_BWT_RST;
			{tx_len_q, tx_pcb_q, tx_nad_q} <= 24'h000000;
			tx_wptr_q <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				session_q <= reg_wdata_in[`TBF_CTRL_SESSION];
			end
			if (reg_wr_in && reg_addr_in == `TBF_REG_CFG) begin
				ifsc_q <= reg_wdata_in[7:0];
				cwi_q <= reg_wdata_in[11:8];
				edc_code_q <= reg_wdata_in[31:24];
				// An over-range receive limit is ignored, old value kept
				if (reg_wdata_in[23:16] <= `TBF_IFS_MAX) begin
					ifsd_q <= reg_wdata_in[23:16];
				end
			end
			if (reg_wr_in && reg_addr_in == `TBF_REG_BWT) begin
				bwt_q <= reg_wdata_in[15:0];
			end
			if (reg_wr_in && reg_addr_in == `TBF_REG_TXHDR && state_q == ST_IDLE) begin
				{tx_len_q, tx_pcb_q, tx_nad_q} <= reg_wdata_in[23:0];
			end
			if (wr_ctrl && reg_wdata_in[`TBF_CTRL_TXCLR] && state_q == ST_IDLE) begin
				tx_wptr_q <= 8'h00;
			end else if (reg_wr_in && reg_addr_in == `TBF_REG_TXDATA && tx_wptr_q < BUF_DEPTH) begin
				tx_wptr_q <= tx_wptr_q + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------------
	// Block sequencer: guard, send, wait for answer, receive
	// ------------------------------------------------------------------
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= ST_IDLE;
			conn_open_q <= 1'b0;
			conn_nad_q <= 8'h00;
			card_turn_q <= 1'b0;
			last_rx_q <= 1'b0;
			idx_q <= 9'h000;
			lrc_q <= 8'h00;
			tx_data_q <= 8'h00;
			tx_valid_q <= 1'b0;
			{rx_len_q, rx_pcb_q, rx_nad_q} <= 24'h000000;
			set_flags <= 9'h000;
		end else begin
			set_flags <= 9'h000;
			// Closing the session drops the connection and the turn
			if (!session_q) begin
				conn_open_q <= 1'b0;
				card_turn_q <= 1'b0;
			end
			if (send_req && !send_ok) begin
				set_flags[`TBF_ST_TX_REFUSED] <= 1'b1;
			end
			case (state_q)
				ST_IDLE: begin
					if (send_req && send_ok) begin
						state_q <= ST_GUARD;
						conn_open_q <= 1'b1;
						conn_nad_q <= tx_nad_q;
					end
				end
				ST_GUARD: begin
					// Turnaround after a card character needs the guard gap
					if (!last_rx_q || etu_cnt_q >= `TBF_BGT_ETU) begin
						state_q <= ST_TX;
						idx_q <= 9'h000;
						lrc_q <= 8'h00;
						tx_data_q <= tx_nad_q;
						tx_valid_q <= 1'b1;
					end
				end
				ST_TX: begin
					if (tx_take) begin
						last_rx_q <= 1'b0;
						lrc_q <= lrc_q ^ tx_data_q;
						if (idx_q == last_idx) begin
							tx_valid_q <= 1'b0;
							card_turn_q <= 1'b1;
							state_q <= ST_WAIT;
						end else begin
							idx_q <= nxt_idx;
							tx_data_q <= nxt_byte;
						end
					end
				end
				ST_WAIT: begin
					if (rx_valid_in) begin
						state_q <= ST_RX;
						last_rx_q <= 1'b1;
						rx_nad_q <= rx_data_in;
						lrc_q <= rx_data_in;
						idx_q <= 9'h001;
					end else if (etu_cnt_q >= bwt_q) begin
						set_flags[`TBF_ST_BWT_TO] <= 1'b1;
						card_turn_q <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				ST_RX: begin
					if (rx_valid_in) begin
						idx_q <= nxt_idx;
						lrc_q <= lrc_q ^ rx_data_in;
						if (idx_q == 9'h001) begin
							rx_pcb_q <= rx_data_in;
						end else if (idx_q == 9'h002) begin
							rx_len_q <= rx_data_in;
						end
						if (idx_q >= 9'h003 && idx_q == rx_last_idx) begin
							// Whole block in: judge it and hand back the turn
							card_turn_q <= 1'b0;
							state_q <= ST_IDLE;
							set_flags[`TBF_ST_RX_DONE] <= 1'b1;
							if (lrc_q != rx_data_in) begin
								set_flags[`TBF_ST_EDC_ERR] <= 1'b1;
							end
							if (!pcb_ok(rx_pcb_q, rx_len_q) || !nad_ok(rx_nad_q)) begin
								set_flags[`TBF_ST_INVALID] <= 1'b1;
							end
							if (rx_len_q > ifsd_q) begin
								set_flags[`TBF_ST_OVERLONG] <= 1'b1;
							end
						end
					end else if (etu_cnt_q > cwt_etu) begin
						// Character gap too long: drop the block, turn returns
						set_flags[`TBF_ST_CWT_ERR] <= 1'b1;
						card_turn_q <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					tx_valid_q <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Sticky status; a set in the same cycle as a clear wins
	// ------------------------------------------------------------------
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_q <= 9'h000;
		end else begin
			status_q[`TBF_ST_BUSY] <= (state_q != ST_IDLE);
			status_q[`TBF_ST_CARD_TURN] <= card_turn_q;
			status_q[8:2] <= (status_q[8:2] & ~(wr_status ? reg_wdata_in[8:2] : 7'h00))
				| set_flags[8:2];
		end
	end

	// ------------------------------------------------------------------
	// Read port: data valid in the cycle after the strobe only
	// ------------------------------------------------------------------
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_q <= 32'h00000000;
			rx_rptr_q <= 8'h00;
		end else begin
			rdata_q <= 32'h00000000;
			if (state_q == ST_WAIT && rx_valid_in) begin
				rx_rptr_q <= 8'h00;
			end else if (rd_rxdata && rx_rptr_q < BUF_DEPTH) begin
				rx_rptr_q <= rx_rptr_q + 8'h01;
			end
			if (reg_rd_in) begin
				case (reg_addr_in)
					`TBF_REG_CTRL: rdata_q <= {30'h00000000, session_q, 1'b0};
					`TBF_REG_CFG: rdata_q <= {edc_code_q, ifsd_q, 4'h0, cwi_q, ifsc_q};
					`TBF_REG_BWT: rdata_q <= {16'h0000, bwt_q};
					`TBF_REG_TXHDR: rdata_q <= {tx_wptr_q, tx_len_q, tx_pcb_q, tx_nad_q};
					`TBF_REG_STATUS: rdata_q <= {23'h000000, status_q};
					`TBF_REG_RXHDR: rdata_q <= {rx_rptr_q, rx_len_q, rx_pcb_q, rx_nad_q};
					`TBF_REG_RXDATA: rdata_q <= {24'h000000, rxbuf[rx_rptr_q]};
					default: rdata_q <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // tbf_host_framer

`default_nettype wire

// ===== pkg/tbf_map.vh
/*
 * Register map, field positions, reset values and etu timing counts of the
 * terminal-side block framer. Assumes inclusion by bare name from hw/ and bench/ files.
 */
`ifndef TBF_MAP_VH
`define TBF_MAP_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define TBF_REG_CTRL 8'h00
`define TBF_REG_CFG 8'h04
`define TBF_REG_BWT 8'h08
`define TBF_REG_TXHDR 8'h0C
`define TBF_REG_TXDATA 8'h10
`define TBF_REG_STATUS 8'h14
`define TBF_REG_RXHDR 8'h18
`define TBF_REG_RXDATA 8'h1C

// ----------------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------------
`define TBF_CTRL_SEND 0
`define TBF_CTRL_SESSION 1
`define TBF_CTRL_TXCLR 2

// ----------------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------------
`define TBF_ST_BUSY 0
`define TBF_ST_CARD_TURN 1
`define TBF_ST_RX_DONE 2
`define TBF_ST_TX_REFUSED 3
`define TBF_ST_BWT_TO 4
`define TBF_ST_CWT_ERR 5
`define TBF_ST_EDC_ERR 6
`define TBF_ST_INVALID 7
`define TBF_ST_OVERLONG 8
`define TBF_ST_STICKY_MASK 9'h1FC

// ----------------------------------------------------------------------
// Reset values and protocol limits
// ----------------------------------------------------------------------
`define TBF_IFS_DEFAULT 8'h20
`define TBF_IFS_MAX 8'hFE
`define TBF_LEN_RFU 8'hFF
`define TBF_CWI_MAX 4'h5
`define TBF_BWT_RST 16'h0F00
`define TBF_BGT_ETU 16'h0016
`define TBF_CWT_BASE_ETU 16'h000B

`endif

// ===== bench/tbf_checker.sv
/* Port assertions for the terminal block framer.
   Assumes the register map header and a one-cycle etu tick. */
`timescale 1ns/100ps
`default_nettype none
`include "tbf_map.vh"
module tbf_checker #(
	parameter BUF_DEPTH = 254
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic etu_tick_in,
	input wire logic [7:0] tx_data_out,
	input wire logic tx_valid_out,
	input wire logic tx_ready_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_valid_in
);
	// ----------------------------------------
	// Shadow of the sent block and of timing
	// ----------------------------------------
	logic [8:0] idx_q;
	logic [7:0] len_q, pcb_q, lrc_q, ifsc_q, edc_q;
	logic sess_q, rxl_q;
	logic [5:0] gap_q;
	wire take = tx_valid_out && tx_ready_in;
	wire last = idx_q > 9'h002 && idx_q == {1'b0, len_q} + 9'h003;
	function automatic logic pcb_ok(input logic [7:0] p);
		return !p[7] ? p[4:0] == 5'h00 : !p[6] ? !p[5] && p[3:0] <= 4'h2 : p[4:0] <= 5'h03;
	endfunction
	// Gap counter saturates so an idle link never wraps into a short gap
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			idx_q <= 9'h000;
			{len_q, pcb_q, lrc_q, edc_q} <= 32'h0;
			ifsc_q <= `TBF_IFS_DEFAULT;
			sess_q <= 1'b0;
			rxl_q <= 1'b0;
			gap_q <= 6'h00;
		end else begin
			if (reg_wr_in && reg_addr_in == `TBF_REG_CFG) begin
				ifsc_q <= reg_wdata_in[7:0];
				edc_q <= reg_wdata_in[31:24];
			end
			if (reg_wr_in && reg_addr_in == `TBF_REG_CTRL)
				sess_q <= reg_wdata_in[1];
			if (rx_valid_in) begin
				rxl_q <= 1'b1;
				gap_q <= 6'h00;
			end else if (etu_tick_in && gap_q != 6'h3F)
				gap_q <= gap_q + 6'h01;
			if (take) begin
				rxl_q <= 1'b0;
				idx_q <= last ? 9'h000 : idx_q + 9'h001;
				lrc_q <= last ? 8'h00 : lrc_q ^ tx_data_out;
				if (idx_q == 9'h001)
					pcb_q <= tx_data_out;
				if (idx_q == 9'h002)
					len_q <= tx_data_out;
			end
		end
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	AST_NODE: assert property (take && idx_q == 9'h000 |-> tx_data_out == 8'h00)
		else $error("node byte not zero");
	AST_PCB: assert property (take && idx_q == 9'h001 |-> pcb_ok(tx_data_out))
		else $error("control byte reserved");
	AST_LEN_FF: assert property (take && idx_q == 9'h002 |-> tx_data_out != 8'hFF)
		else $error("length FF sent");
	AST_LEN_IFSC: assert property (take && idx_q == 9'h002 |-> tx_data_out <= ifsc_q)
		else $error("length above card limit");
	AST_S_LEN: assert property (take && idx_q == 9'h002 && pcb_q[7]
		|-> tx_data_out == {7'h00, pcb_q[6] & pcb_q[0]})
		else $error("supervisory length wrong");
	AST_LRC: assert property (take && last |-> tx_data_out == lrc_q)
		else $error("check byte wrong");
	AST_GUARD: assert property (take && rxl_q |-> gap_q >= 6'd22)
		else $error("turnaround too short");
	AST_SESSION: assert property ($rose(tx_valid_out) |-> sess_q)
		else $error("block outside session");
	AST_EDC: assert property ($rose(tx_valid_out) |-> edc_q == 8'h00)
		else $error("block with bad code byte");
	AST_HOLD: assert property (tx_valid_out && !tx_ready_in
		|=> tx_valid_out && $stable(tx_data_out))
		else $error("byte dropped before taken");
	C_LAST: cover property (take && last);
	C_TURN: cover property (take && rxl_q);
	C_STALL: cover property (tx_valid_out && !tx_ready_in);
endmodule // tbf_checker
bind tbf_host_framer tbf_checker #(.BUF_DEPTH(BUF_DEPTH)) u_chk (.ref_clk_in(ref_clk_in),
	.rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.etu_tick_in(etu_tick_in), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
	.tx_ready_in(tx_ready_in), .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in));
`default_nettype wire

// ===== bench/tbf_card_model.sv
/* Behavioural card and character layer: takes blocks, answers one block.
   Assumes one clock; makes an etu tick every fourth cycle. */
`timescale 1ns/100ps
`default_nettype none
module tbf_card_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	output logic etu_tick_out,
	input wire logic slow_in,
	input wire logic mute_in,
	input wire logic bad_lrc_in,
	input wire logic stall_in,
	input wire logic [7:0] pcb_in,
	input wire logic [7:0] len_in,
	input wire logic [7:0] gap_in
);
	// ----------------------------------------
	// Capture and answer
	// ----------------------------------------
	logic [7:0] cap [0:1023];
	logic [7:0] rpcb, rlen, lrc, b;
	logic [1:0] div_q;
	logic busy, over;
	int cap_n, bi, need, j, wt;
	// Slow mode takes a byte only on a tick
	assign tx_ready_out = !slow_in || etu_tick_out;
	// Idle data toggles so a stale byte never looks valid
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_q <= 2'h0;
			etu_tick_out <= 1'b0;
			rx_valid_out <= 1'b0;
			rx_data_out <= 8'h5A;
			cap_n = 0;
			bi = 0;
			need = 4;
			busy = 1'b0;
		end else begin
			div_q <= div_q + 2'h1;
			etu_tick_out <= (div_q == 2'h3);
			rx_valid_out <= 1'b0;
			rx_data_out <= ~rx_data_out;
			if (tx_valid_in && tx_ready_out) begin
				cap[cap_n] = tx_data_in;
				cap_n++;
				bi++;
				if (bi == 3) begin
					need = tx_data_in + 4;
					over = tx_data_in > 8'h20;
				end
				if (bi == need) begin
					bi = 0;
					busy = !mute_in;
					j = 0;
					wt = gap_in;
					lrc = 8'h00;
					rpcb = over ? 8'h82 : pcb_in;
					rlen = over ? 8'h00 : len_in;
				end
			end
			if (busy && etu_tick_out) begin
				wt--;
				if (wt == 0) begin
					b = j == 0 ? 8'h00 : j == 1 ? rpcb : j == 2 ? rlen :
						j < rlen + 3 ? 8'hA0 + 8'(j) : lrc ^ {7'h00, bad_lrc_in};
					rx_data_out <= b;
					rx_valid_out <= 1'b1;
					lrc = lrc ^ b;
					j++;
					wt = (stall_in && j == 3) ? 20 : 2;
					busy = j < rlen + 4;
				end
			end
		end
	end
endmodule // tbf_card_model
`default_nettype wire

// ===== bench/tb_t1_block_protocol_framer.sv
/* Self-checking bench for the terminal block framer.
   Assumes the card model on the link and the bound port checker. */
`timescale 1ns/100ps
`default_nettype none
`include "tbf_map.vh"
module tb_t1_block_protocol_framer;
	// ----------------------------------------
	// Stimulus and helpers
	// ----------------------------------------
	logic clk, rst_n, wr_s, rd_s, slow, mute, bad, stall, tx_ready, rx_valid, etu, tx_valid;
	logic [7:0] addr, pcb, len, gap, tx_data, rx_data;
	logic [31:0] wdata, rdata, s;
	int error_cnt, checked;
	tbf_host_framer dut (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
		.etu_tick_in(etu), .tx_data_out(tx_data), .tx_valid_out(tx_valid),
		.tx_ready_in(tx_ready), .rx_data_in(rx_data), .rx_valid_in(rx_valid));
	tbf_card_model card (.clk_in(clk), .rst_n_in(rst_n), .tx_data_in(tx_data),
		.tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .rx_data_out(rx_data),
		.rx_valid_out(rx_valid), .etu_tick_out(etu), .slow_in(slow), .mute_in(mute),
		.bad_lrc_in(bad), .stall_in(stall), .pcb_in(pcb), .len_in(len), .gap_in(gap));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic conclude;
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s got %h want %h", $time, m, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	// Send one block and judge the card's side and the sticky flags
	task automatic xfer(input logic [23:0] h, input logic ok, input logic [6:0] fl);
		int n0, n;
		logic [7:0] x;
		wr(`TBF_REG_CTRL, 32'h6);
		for (int i = 0; i < h[23:16]; i++)
			wr(`TBF_REG_TXDATA, 32'h10 + i);
		wr(`TBF_REG_TXHDR, {8'h00, h});
		n0 = card.cap_n;
		wr(`TBF_REG_CTRL, 32'h3);
		n = 0;
		s = 32'h1;
		while (s[0] !== 1'b0 && n < 600) begin
			rd(`TBF_REG_STATUS, s);
			n++;
		end
		if (n >= 600) begin
			chk(n, 0, "busy stuck");
			conclude();
		end
		repeat (4) @(posedge clk);
		rd(`TBF_REG_STATUS, s);
		chk(s[8:2], ok ? fl : 7'h02, "flags");
		chk(card.cap_n - n0, ok ? h[23:16] + 4 : 0, "sent count");
		x = 8'h00;
		for (int i = 0; ok && i < h[23:16] + 4; i++) begin
			chk(card.cap[n0 + i], i == 1 ? h[15:8] : i == 2 ? h[23:16] : i == 0 ? 8'h00 :
				i < h[23:16] + 3 ? 8'h10 + i - 3 : x, "tx byte");
			x = x ^ card.cap[n0 + i];
		end
		wr(`TBF_REG_STATUS, `TBF_ST_STICKY_MASK);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_regs;
		rd(`TBF_REG_CFG, s);
		chk(s, 32'h0020_0020, "cfg reset");
		rd(`TBF_REG_BWT, s);
		chk(s, 32'h0000_0F00, "bwt reset");
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, s);
		chk(s, 32'h0, "unmapped");
		wr(`TBF_REG_CFG, 32'h00FE_0020);
		wr(`TBF_REG_CFG, 32'h00FF_0020);
		rd(`TBF_REG_CFG, s);
		chk(s, 32'h00FE_0020, "ifsd cap");
		wr(`TBF_REG_CFG, 32'h0020_0020);
		wr(`TBF_REG_CTRL, 32'h1);
		repeat (4) @(posedge clk);
		rd(`TBF_REG_STATUS, s);
		chk(s[8:0], 9'h008, "send without session");
		wr(`TBF_REG_STATUS, `TBF_ST_STICKY_MASK);
	endtask
	task automatic s_rx;
		xfer(24'h020000, 1'b1, 7'h01);
		rd(`TBF_REG_RXHDR, s);
		chk(s[23:0], 24'h010000, "rx header");
		rd(`TBF_REG_RXDATA, s);
		chk(s[7:0], 8'hA3, "rx data");
	endtask
	// Control codings, length edges and node bytes 00, 10 and 80, {accept, len, pcb, node}
	task automatic s_codes;
		logic [24:0] t [0:21];
		t = '{25'h1020000, 25'h1200000, 25'h1004000, 25'h1002000, 25'h1008000, 25'h1008100,
			25'h1008200, 25'h1009000, 25'h100C000, 25'h101C100, 25'h100C200, 25'h101C300,
			25'h101E100, 25'h0000100, 25'h0008300, 25'h0018000, 25'h000C400, 25'h000C100,
			25'h0210000, 25'h0FF0000, 25'h0000010, 25'h0000080};
		for (int i = 0; i < 22; i++)
			xfer(t[i][23:0], t[i][24], 7'h01);
	endtask
	task automatic s_faults;
		bad <= 1'b1;
		xfer(24'h0, 1'b1, 7'h11);
		bad <= 1'b0;
		pcb <= 8'h85;
		xfer(24'h0, 1'b1, 7'h21);
		pcb <= 8'h00;
		len <= 8'h14;
		wr(`TBF_REG_CFG, 32'h0010_0020);
		xfer(24'h0, 1'b1, 7'h41);
		len <= 8'h01;
		wr(`TBF_REG_BWT, 32'd40);
		mute <= 1'b1;
		xfer(24'h0, 1'b1, 7'h04);
		mute <= 1'b0;
		stall <= 1'b1;
		xfer(24'h0, 1'b1, 7'h08);
		repeat (300) @(posedge clk);
		wr(`TBF_REG_CFG, 32'h0020_0720);
		xfer(24'h0, 1'b1, 7'h01);
		stall <= 1'b0;
		wr(`TBF_REG_CFG, 32'h0120_0020);
		xfer(24'h0, 1'b0, 7'h00);
	endtask
	// Main sequence
	initial begin
		{rst_n, wr_s, rd_s, slow, mute, bad, stall} = 7'h00;
		{addr, wdata, pcb} = 48'h0;
		len = 8'h01;
		gap = 8'd24;
		error_cnt = 0;
		checked = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		s_regs();
		s_rx();
		slow <= 1'b1;
		s_codes();
		slow <= 1'b0;
		s_faults();
		conclude();
	end
endmodule // tb_t1_block_protocol_framer
`default_nettype wire
